// ===== design/hbp_pkg.sv
// Purpose: Shared constants and types for the host bus port with counter readout.
// Assumes: Eight-bit host data bus, eleven-bit address bus, one 100 MHz clock.
// Notes:   Offsets are byte addresses on the host address bus.
package hbp_pkg;

  localparam int          ADDR_W            = 11;
  localparam int          DATA_W            = 8;
  localparam int          CNT_W             = 16;
  localparam logic [10:0] ADDR_VIOL_HIGH    = 11'h050;
  localparam logic [10:0] ADDR_VIOL_LOW     = 11'h051;
  localparam logic [10:0] ADDR_HOLD         = 11'h06c;
  localparam logic [10:0] ADDR_CTRL         = 11'h000;
  localparam logic [10:0] ADDR_STATUS       = 11'h001;
  localparam logic [10:0] ADDR_LLM_BASE     = 11'h400;
  localparam logic [10:0] ADDR_MC_BASE      = 11'h600;
  localparam int          BUF_AW            = 9;
  localparam logic [7:0]  CTRL_RESET        = 8'h00;
  localparam logic [15:0] CNT_RESET         = 16'h0000;
  localparam logic [7:0]  HOLD_RESET        = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA     = 8'h00;
  // Data settling time before ready rises, in ns, and its cycle count.
  localparam int          SETTLE_NS         = 20;
  localparam int          CLK_NS            = 10;
  localparam int          SETTLE_CYC        = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  SETTLE_CYC_W      = 4'(SETTLE_CYC);

  // Host port pins after synchronisation.
  typedef struct packed {
    logic        chip_select_n;
    logic        address_latch_strobe;
    logic        read_data_strobe_n;
    logic        write_strobe_n;
    logic [10:0] addr;
    logic [7:0]  wdata;
  } hbp_pins_t;

  // Idle levels of the host pins, shown by the synchroniser during reset.
  localparam hbp_pins_t   PINS_IDLE         = '{1'b1, 1'b0, 1'b1, 1'b1, 11'h000, 8'h00};

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_READY  = 2'b10,
    ST_WRITE  = 2'b11
  } hbp_state_t;

endpackage : hbp_pkg

// ===== design/hbp_sync.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes: Every bit is an independent level from outside the clock domain.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ns
module hbp_sync
  import hbp_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1_q;
  logic [W-1:0] stage1_d;
  logic [W-1:0] q_d;

  // Next values of both stages; reset parks lines at zero.
  always_comb begin
    stage1_d = reset_n ? d : '0;
    q_d      = reset_n ? stage1_q : '0;
  end

  // Register both stages.
  always_ff @(posedge clk_sys) begin
    stage1_q <= stage1_d;
    q        <= q_d;
  end

endmodule : hbp_sync

// ===== design/hbp_host_port.sv
// Purpose: Eight-bit asynchronous-strobe host port with counter readout.
// Assumes: Host strobes are asynchronous and pass two flip-flops first.
// Notes:   Only the latch-enable style cycle is handled in depth; strap high
//          selects a simplified strobe-select cycle.
`timescale 1ns/1ns
module hbp_host_port
  import hbp_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              bus_style_strap,
  input  wire logic              chip_select_n,
  input  wire logic              address_latch_strobe,
  input  wire logic              read_data_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe,
  output logic                   transfer_ready_ack,
  input  wire logic              line_code_violation,
  input  wire logic              llm_wr_en,
  input  wire logic [BUF_AW-1:0] llm_wr_addr,
  input  wire logic [DATA_W-1:0] llm_wr_data,
  input  wire logic              mc_wr_en,
  input  wire logic [BUF_AW-1:0] mc_wr_addr,
  input  wire logic [DATA_W-1:0] mc_wr_data,
  output logic      [DATA_W-1:0] ctrl_reg
);

  localparam int PW = $bits(hbp_pins_t);

  hbp_pins_t   pins_raw;
  hbp_pins_t   pins;
  logic [PW-1:0] pins_flip;
  logic [1:0]  misc_s;
  logic        strap_s;
  logic        viol_s;
  logic        als_prev_q;
  logic        als_prev_d;
  logic        strb_prev_q;
  logic        strb_prev_d;
  logic [10:0] addr_q;
  logic [10:0] addr_d;
  hbp_state_t  state_q;
  hbp_state_t  state_d;
  logic [3:0]  settle_q;
  logic [3:0]  settle_d;
  logic [15:0] viol_cnt_q;
  logic [15:0] viol_cnt_d;
  logic [7:0]  hold_q;
  logic [7:0]  hold_d;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [7:0]  llm_mem_q [2**BUF_AW];
  logic [7:0]  mc_mem_q  [2**BUF_AW];
  logic [7:0]  rdata_d;
  logic [7:0]  dout_q;
  logic        oe_q;
  logic        rdy_q;
  logic [7:0]  dout_d;
  logic        oe_d;
  logic        rdy_d;
  logic        rd_act;
  logic        wr_act;
  logic        rd_take;

  assign pins_raw = '{chip_select_n, address_latch_strobe, read_data_strobe_n,
                      write_strobe_n, addr, data_in};

  // Pins and events cross into the clock domain through two flops.
  // Idle levels are folded out around the synchroniser, so its cleared
  // stages read as idle pins and reset release is not taken as a read.
  hbp_sync #(.W(PW)) u_sync_pins (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .d       (pins_raw ^ PINS_IDLE),
    .q       (pins_flip)
  );

  assign pins = hbp_pins_t'(pins_flip ^ PINS_IDLE);

  hbp_sync #(.W(2)) u_sync_misc (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .d       ({bus_style_strap, line_code_violation}),
    .q       (misc_s)
  );

  assign strap_s = misc_s[1];
  assign viol_s  = misc_s[0];

  // Decode the active cycle from the strap-selected protocol.
  always_comb begin
    if (!strap_s) begin
      rd_act = !pins.chip_select_n && !pins.read_data_strobe_n;
      wr_act = !pins.chip_select_n && !pins.write_strobe_n;
    end else begin
      rd_act = !pins.chip_select_n && !pins.read_data_strobe_n && pins.write_strobe_n;
      wr_act = !pins.chip_select_n && !pins.read_data_strobe_n && !pins.write_strobe_n;
    end
  end

  // Address latch: falling edge with strap low, rising edge otherwise.
  always_comb begin
    als_prev_d = reset_n ? pins.address_latch_strobe : 1'b0;
    addr_d     = addr_q;
    if (!pins.chip_select_n) begin
      if (!strap_s && als_prev_q && !pins.address_latch_strobe) begin
        addr_d = pins.addr;
      end else if (strap_s && !als_prev_q && pins.address_latch_strobe) begin
        addr_d = pins.addr;
      end
    end
    if (!reset_n) begin
      addr_d = '0;
    end
  end

  // Read mux over registers and both receive buffers.
  always_comb begin
    rdata_d = UNMAPPED_DATA;
    if (addr_q >= ADDR_MC_BASE) begin
      rdata_d = mc_mem_q[addr_q[BUF_AW-1:0]];
    end else if (addr_q >= ADDR_LLM_BASE) begin
      rdata_d = llm_mem_q[addr_q[BUF_AW-1:0]];
    end else begin
      case (addr_q)
        ADDR_CTRL:     rdata_d = ctrl_q;
        ADDR_STATUS:   rdata_d = {6'h00, strap_s, rdy_q};
        ADDR_VIOL_HIGH: rdata_d = viol_cnt_q[15:8];
        ADDR_VIOL_LOW:  rdata_d = viol_cnt_q[7:0];
        ADDR_HOLD:     rdata_d = hold_q;
        default:       rdata_d = UNMAPPED_DATA;
      endcase
    end
  end

  // Handshake state machine for one programmed transfer.
  always_comb begin
    state_d     = state_q;
    settle_d    = settle_q;
    dout_d      = dout_q;
    oe_d        = oe_q;
    rdy_d       = rdy_q;
    rd_take     = 1'b0;
    strb_prev_d = wr_act;
    ctrl_d      = ctrl_q;
    case (state_q)
      ST_IDLE: begin
        rdy_d = 1'b1;
        oe_d  = 1'b0;
        if (rd_act) begin
          rdy_d    = 1'b0;
          oe_d     = 1'b1;
          dout_d   = rdata_d;
          rd_take  = 1'b1;
          settle_d = SETTLE_CYC_W;
          state_d  = ST_SETTLE;
        end else if (wr_act) begin
          state_d = ST_WRITE;
        end
      end
      ST_SETTLE: begin
        if (settle_q <= 4'h1) begin
          rdy_d   = 1'b1;
          state_d = ST_READY;
        end else begin
          settle_d = settle_q - 4'h1;
        end
      end
      ST_READY: begin
        if (!rd_act) begin
          oe_d    = 1'b0;
          state_d = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (strb_prev_q && !wr_act) begin
          if (addr_q == ADDR_CTRL) begin
            ctrl_d = pins.wdata;
          end
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (!reset_n) begin
      state_d     = ST_IDLE;
      settle_d    = '0;
      dout_d      = '0;
      oe_d        = 1'b0;
      rdy_d       = 1'b1;
      strb_prev_d = 1'b0;
      ctrl_d      = CTRL_RESET;
    end
  end

  // Counter clear on byte read and capture of the complementary byte.
  always_comb begin
    viol_cnt_d = viol_cnt_q;
    hold_d     = hold_q;
    if (rd_take && (addr_q == ADDR_VIOL_HIGH)) begin
      hold_d     = viol_cnt_q[7:0];
      viol_cnt_d = CNT_RESET;
    end else if (rd_take && (addr_q == ADDR_VIOL_LOW)) begin
      hold_d     = viol_cnt_q[15:8];
      viol_cnt_d = CNT_RESET;
    end
    // An event in the clearing cycle counts from zero, so it is not lost.
    if (viol_s && (viol_cnt_d != 16'hffff)) begin
      viol_cnt_d = viol_cnt_d + 16'h0001;
    end
    if (!reset_n) begin
      viol_cnt_d = CNT_RESET;
      hold_d     = HOLD_RESET;
    end
  end

  // Register all control state.
  always_ff @(posedge clk_sys) begin
    als_prev_q  <= als_prev_d;
    strb_prev_q <= strb_prev_d;
    addr_q      <= addr_d;
    state_q     <= state_d;
    settle_q    <= settle_d;
    dout_q      <= dout_d;
    oe_q        <= oe_d;
    rdy_q       <= rdy_d;
    ctrl_q      <= ctrl_d;
    viol_cnt_q  <= viol_cnt_d;
    hold_q      <= hold_d;
  end

  // Receive buffers are filled by the receive datapath.
  always_ff @(posedge clk_sys) begin
    if (llm_wr_en) begin
      llm_mem_q[llm_wr_addr] <= llm_wr_data;
    end
    if (mc_wr_en) begin
      mc_mem_q[mc_wr_addr] <= mc_wr_data;
    end
  end

  assign data_out           = dout_q;
  assign data_oe            = oe_q;
  assign transfer_ready_ack = rdy_q;
  assign ctrl_reg           = ctrl_q;

endmodule : hbp_host_port

// ===== verif/hbp_host_port_properties.sv
// Purpose: Timing checks on the host read cycle of the port.
// Assumes: Either strap setting; the checks are common to both cycles.
// Notes:   Bound to every instance of the host port.
`timescale 1ns/1ns
module hbp_port_chk
  import hbp_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              chip_select_n,
  input wire logic              read_data_strobe_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe,
  input wire logic              transfer_ready_ack
);
  // All checks share the system clock and reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  chk_ready_drops: assert property ($rose(data_oe) |-> !transfer_ready_ack)
    else $error("ready not low when drive starts");
  chk_ready_settles: assert property ($rose(data_oe) |->
    !transfer_ready_ack [*2] ##1 transfer_ready_ack && data_oe)
    else $error("ready late or early");
  chk_ready_only_read: assert property ($fell(transfer_ready_ack) |-> data_oe)
    else $error("ready dropped outside a read");
  chk_drive_needs_rd: assert property (data_oe |->
    $past(!read_data_strobe_n && !chip_select_n, 3))
    else $error("bus driven without a read strobe");
  chk_bus_release: assert property ($rose(read_data_strobe_n) && data_oe |->
    ##[1:4] !data_oe)
    else $error("bus not released after strobe");
  chk_release_ready: assert property ($fell(data_oe) |-> transfer_ready_ack)
    else $error("ready low after release");
  chk_data_stands: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("read data moved while driven");
  chk_idle_quiet: assert property (chip_select_n [*4] |-> !data_oe)
    else $error("bus driven while not selected");
endmodule : hbp_port_chk

bind hbp_host_port hbp_port_chk u_chk (.clk_sys, .reset_n, .chip_select_n,
  .read_data_strobe_n, .data_out, .data_oe, .transfer_ready_ack);

// ===== verif/hbp_host_model.sv
// Purpose: Host processor model driving reads in either strap setting and writes with strap low only.
// Assumes: Signals change just after a rising edge.
// Notes:   An undriven data bus shows the inverse of the last value.
`timescale 1ns/1ns
module hbp_host_bfm
  import hbp_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe,
  input  wire logic              transfer_ready_ack,
  input  wire logic              bus_style_strap,
  output logic                   chip_select_n,
  output logic                   address_latch_strobe,
  output logic                   read_data_strobe_n,
  output logic                   write_strobe_n,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] data_in
);
  logic [DATA_W-1:0] dbus;
  // Bus level seen by the host.
  assign dbus = data_oe ? data_out : ~data_out;
  // Idle levels at time zero.
  initial begin
    chip_select_n = 1'b1;
    address_latch_strobe = 1'b0;
    read_data_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    addr = '0;
    data_in = '0;
  end
  // Address phase with chip select low, then latch on the strobe edge the strap selects.
  task automatic latch(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    chip_select_n <= 1'b0;
    address_latch_strobe <= !bus_style_strap;
    addr <= a;
    repeat (3) @(posedge clk_sys);
    address_latch_strobe <= bus_style_strap;
    repeat (3) @(posedge clk_sys);
    addr <= ~a;
  endtask : latch
  // Read cycle, held until ready is seen with the bus driven.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    int n;
    n = 0;
    latch(a);
    read_data_strobe_n <= 1'b0;
    @(posedge clk_sys);
    while (!(data_oe === 1'b1 && transfer_ready_ack === 1'b1) && n < 30) begin
      @(posedge clk_sys);
      n++;
    end
    d = dbus;
    // A read that never became ready hands back unknown data.
    if (!(data_oe === 1'b1 && transfer_ready_ack === 1'b1)) d = 'x;
    read_data_strobe_n <= 1'b1;
    chip_select_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : rd
  // Write cycle, data latched as the write strobe rises.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    latch(a);
    write_strobe_n <= 1'b0;
    data_in <= d;
    repeat (3) @(posedge clk_sys);
    write_strobe_n <= 1'b1;
    chip_select_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    data_in <= ~d;
    @(posedge clk_sys);
  endtask : wr
endmodule : hbp_host_bfm

// ===== verif/test_hbp_host_port.sv
// Purpose: Self-checking bench for the host port counter readout.
// Assumes: Strap low except in the strap scenario, one 100 MHz clock.
// Notes:   Counter values are built by holding the event input high.
`timescale 1ns/1ns
module test_hbp_host_port;
  import hbp_pkg::*;
  logic              clk_sys, reset_n, line_code_violation, bus_style_strap;
  logic              chip_select_n, address_latch_strobe;
  logic              read_data_strobe_n, write_strobe_n, data_oe, transfer_ready_ack;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_in, data_out, ctrl_reg, llm_wr_data, mc_wr_data;
  logic              llm_wr_en, mc_wr_en;
  logic [BUF_AW-1:0] llm_wr_addr, mc_wr_addr;
  int                fail_count, checks_done, cyc;
  hbp_host_port uut (.clk_sys, .reset_n, .bus_style_strap, .chip_select_n,
    .address_latch_strobe, .read_data_strobe_n, .write_strobe_n, .addr, .data_in,
    .data_out, .data_oe, .transfer_ready_ack, .line_code_violation, .llm_wr_en,
    .llm_wr_addr, .llm_wr_data, .mc_wr_en, .mc_wr_addr, .mc_wr_data, .ctrl_reg);
  hbp_host_bfm host (.clk_sys, .bus_style_strap, .data_out, .data_oe, .transfer_ready_ack,
    .chip_select_n, .address_latch_strobe, .read_data_strobe_n, .write_strobe_n,
    .addr, .data_in);
  // Free-running clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    host.rd(a, d);
    check(d, exp);
  endtask : rdchk
  // Holds the event input high for n sampled edges.
  task automatic events(input int n);
    @(posedge clk_sys);
    line_code_violation <= 1'b1;
    repeat (n) @(posedge clk_sys);
    line_code_violation <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : events
  task automatic t_high_first();
    rdchk(ADDR_HOLD, HOLD_RESET);
    events(300);
    rdchk(ADDR_VIOL_HIGH, 8'h01);
    rdchk(ADDR_HOLD, 8'h2c);
    rdchk(ADDR_VIOL_LOW, 8'h00);
    rdchk(ADDR_HOLD, 8'h00);
    $display("t_high_first done");
  endtask : t_high_first
  task automatic t_low_first();
    events(515);
    rdchk(ADDR_VIOL_LOW, 8'h03);
    rdchk(ADDR_HOLD, 8'h02);
    rdchk(ADDR_HOLD, 8'h02);
    rdchk(ADDR_VIOL_HIGH, 8'h00);
    $display("t_low_first done");
  endtask : t_low_first
  task automatic t_regs();
    host.wr(ADDR_CTRL, 8'ha5);
    check(ctrl_reg, 8'ha5);
    rdchk(ADDR_CTRL, 8'ha5);
    rdchk(11'h100, UNMAPPED_DATA);
    @(posedge clk_sys);
    llm_wr_en <= 1'b1;
    mc_wr_en <= 1'b1;
    llm_wr_addr <= 9'h003;
    mc_wr_addr <= 9'h1ff;
    llm_wr_data <= 8'h3c;
    mc_wr_data <= 8'hc3;
    @(posedge clk_sys);
    llm_wr_en <= 1'b0;
    mc_wr_en <= 1'b0;
    rdchk(ADDR_LLM_BASE + 11'h003, 8'h3c);
    rdchk(11'h7ff, 8'hc3);
    $display("t_regs done");
  endtask : t_regs
  // Status shows the strap; strap high runs the strobe-select read cycle.
  task automatic t_strap();
    rdchk(ADDR_STATUS, 8'h01);
    @(posedge clk_sys);
    bus_style_strap <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdchk(ADDR_STATUS, 8'h03);
    rdchk(ADDR_CTRL, 8'ha5);
    @(posedge clk_sys);
    bus_style_strap <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rdchk(ADDR_CTRL, 8'ha5);
    $display("t_strap done");
  endtask : t_strap
  // Reset, then the scenarios in turn.
  initial begin
    reset_n = 1'b0;
    line_code_violation = 1'b0;
    bus_style_strap = 1'b0;
    {llm_wr_en, mc_wr_en, llm_wr_addr, mc_wr_addr, llm_wr_data, mc_wr_data} = '0;
    {fail_count, checks_done, cyc} = '0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_high_first();
    t_low_first();
    t_regs();
    t_strap();
    report_and_stop();
  end
endmodule : test_hbp_host_port
